/* rtl/tel_delay.v */
// Prescaler and delay countdown of one thread
`timescale 1ns/10ps
`include "tel_map.vh"
module tel_delay #(
	parameter CNT_W = `TEL_CNT_W,
	parameter PSC_W = `TEL_PSC_W
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire start,
	input wire thr_reset,
	input wire load,
	input wire [CNT_W-1:0] load_value,
	input wire [PSC_W-1:0] prescale_period,
	output wire [CNT_W-1:0] count,
	output wire busy,
	output wire done
);
	reg [PSC_W-1:0] psc_reg;
	reg [CNT_W-1:0] count_reg;
	reg busy_reg;
	reg done_reg;
	wire step;

	assign step = busy_reg && (psc_reg == {PSC_W{1'b0}});
	assign count = count_reg;
	assign busy = busy_reg;
	assign done = done_reg;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			psc_reg <= {PSC_W{1'b0}};
			count_reg <= {CNT_W{1'b0}};
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (ce) begin
			done_reg <= 1'b0;
			if (thr_reset) begin
				psc_reg <= {PSC_W{1'b0}};
				busy_reg <= 1'b0;
			end else if (start) begin
				psc_reg <= prescale_period;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				// One counter step per full prescaler period of period+1 cycles
				if (step) begin
					psc_reg <= prescale_period;
					if (count_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
					end
				end else begin
					psc_reg <= psc_reg - {{(PSC_W-1){1'b0}}, 1'b1};
				end
			end
			if (load) begin
				count_reg <= load_value;
			end else if (step && count_reg != {CNT_W{1'b0}}) begin
				count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // tel_delay

/* rtl/tel_map.vh */
// Register map, field positions and codes for the thread event latch block
`ifndef TEL_MAP_VH
`define TEL_MAP_VH
`define TEL_NUM_THREADS 6
`define TEL_EVT_W 16
`define TEL_CNT_W 12
`define TEL_PSC_W 8
`define TEL_THREAD_HI 7
`define TEL_THREAD_LO 4
`define TEL_REG_HI 3
`define TEL_REG_LO 0
`define TEL_REG_DLY_LO 4'h0
`define TEL_REG_DLY_HI 4'h1
`define TEL_REG_EN_LO 4'h2
`define TEL_REG_EN_HI 4'h3
`define TEL_REG_PEND_LO 4'h4
`define TEL_REG_PEND_HI 4'h5
`define TEL_REG_PERIOD 4'h6
`define TEL_REG_SET_CTRL 4'h7
`define TEL_REG_THR_CTRL 4'h8
`define TEL_IRQ_PAGE 4'h6
`define TEL_REG_IRQ_STATUS 4'h0
`define TEL_REG_IRQ_CLEAR 4'h1
`define TEL_REG_IRQ_ENABLE 4'h2
`define TEL_SET_BITS_HI 3
`define TEL_SET_BITS_LO 0
`define TEL_SET_SEL_HI 5
`define TEL_SET_SEL_LO 4
`define TEL_DLY_HI_W 4
`define TEL_THR_RESET_BIT 6
`define TEL_THR_STATE_HI 7
`define TEL_THR_STATE_LO 6
`define TEL_ST_STOPPED 2'h0
`define TEL_ST_ACTIVE 2'h1
`define TEL_ST_WAIT_EVT 2'h2
`define TEL_ST_WAIT_DLY 2'h3
`define TEL_OP_START 2'h0
`define TEL_OP_CLEAR 2'h1
`define TEL_OP_AWAIT 2'h2
`define TEL_OP_TIMED 2'h3
`define TEL_BYTE_RST 8'h00
`endif

/* rtl/tel_pending.v */
// Sticky event pending flags of one thread with their set and clear priorities
`timescale 1ns/10ps
`include "tel_map.vh"
module tel_pending #(
	parameter EVT_W = `TEL_EVT_W
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire [EVT_W-1:0] evt,
	input wire [EVT_W-1:0] accept_en,
	input wire [EVT_W-1:0] instr_clr,
	input wire wr_lo,
	input wire wr_hi,
	input wire [7:0] wr_data,
	input wire [EVT_W-1:0] set_mask,
	output wire [EVT_W-1:0] flags
);
	reg [EVT_W-1:0] event_pending_flag_reg;
	reg [EVT_W-1:0] event_pending_flag_next;
	reg [EVT_W-1:0] cpu_bytes;
	reg [EVT_W-1:0] cpu_ones;
	wire [EVT_W-1:0] ev_set;

	assign ev_set = evt & accept_en;
	assign flags = event_pending_flag_reg;

	always @* begin
		cpu_bytes = {{8{wr_hi}}, {8{wr_lo}}};
		cpu_ones = cpu_bytes & {wr_data, wr_data};
		// Instruction clear is dropped on bytes the processor writes this cycle
		event_pending_flag_next = event_pending_flag_reg & ~(instr_clr & ~cpu_bytes);
		event_pending_flag_next = event_pending_flag_next | ev_set;
		event_pending_flag_next = event_pending_flag_next & ~cpu_ones;
		event_pending_flag_next = event_pending_flag_next | set_mask;
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			event_pending_flag_reg <= {EVT_W{1'b0}};
		end else if (ce) begin
			event_pending_flag_reg <= event_pending_flag_next;
		end
	end
endmodule // tel_pending

/* rtl/tel_top.v */
// Per-thread event latches, pending-set port and delay timing registers
//
// Functional notes
// - An enabled event sets its thread's matching pending flag.
// - A disabled event is ignored and leaves the pending flag unchanged.
// - Pending flags read 1 while set; writing 1 clears, writing 0 keeps.
// - Clear-event or await-event instruction clears the matching pending flag.
// - Event set loses against a processor clear or a set-port set.
// - Processor write beats a simultaneous instruction clear of the same flag.
// - Set field bits set flags; select 0 maps flags 3..0, select 1 flags 7..4.
// - Select 2 maps flags 11..8, select 3 flags 15..12, bit 3 highest.
// - Reserved bits of set control and counter high read zero.
// - During timed wait the prescaler reloads and counts period down to zero.
// - Delay counter steps once per prescaler cycle, period plus one clocks.
// - Counter upper four bits sit in bits 3..0 of the high register.
// - A processor counter write beats a simultaneous unit update.
// - Low byte write is buffered and committed with the high byte write.
// - Low byte read captures the high byte; high byte read returns it.
// - Thread state codes: 2 waits for an event, 3 waits for delay.
// - Writing 1 to thread reset clears thread state and prescaler.
`timescale 1ns/10ps
`include "tel_map.vh"
module tel_top #(
	parameter NUM_THREADS = `TEL_NUM_THREADS,
	parameter EVT_W = `TEL_EVT_W,
	parameter CNT_W = `TEL_CNT_W,
	parameter PSC_W = `TEL_PSC_W
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire [7:0] addr,
	input wire [7:0] wr_data,
	input wire wr_en,
	input wire rd_en,
	output wire [7:0] rd_data,
	input wire [NUM_THREADS*EVT_W-1:0] evt_in,
	input wire [NUM_THREADS-1:0] instr_valid,
	input wire [NUM_THREADS*2-1:0] instr_op,
	input wire [NUM_THREADS*4-1:0] instr_evt,
	output wire [NUM_THREADS*2-1:0] thread_state,
	output wire irq
);
	wire [3:0] thr_idx;
	wire [3:0] reg_idx;
	wire [NUM_THREADS*EVT_W-1:0] en_flat;
	wire [NUM_THREADS*EVT_W-1:0] pend_flat;
	wire [NUM_THREADS*PSC_W-1:0] period_flat;
	wire [NUM_THREADS*CNT_W-1:0] count_flat;
	wire [NUM_THREADS*`TEL_DLY_HI_W-1:0] rbuf_flat;
	wire [NUM_THREADS*2-1:0] state_flat;
	wire [NUM_THREADS-1:0] done_flat;
	wire irq_page;
	wire irq_clr_wr;
	wire irq_en_wr;
	reg [7:0] rd_data_reg;
	reg [7:0] rd_data_next;
	reg irq_reg;
	reg [NUM_THREADS-1:0] irq_status_reg;
	reg [NUM_THREADS-1:0] irq_status_next;
	reg [NUM_THREADS-1:0] irq_enable_reg;
	reg [NUM_THREADS*2-1:0] thread_state_reg;

	assign thr_idx = addr[`TEL_THREAD_HI:`TEL_THREAD_LO];
	assign reg_idx = addr[`TEL_REG_HI:`TEL_REG_LO];
	assign irq_page = (thr_idx == `TEL_IRQ_PAGE);
	assign irq_clr_wr = wr_en && irq_page && reg_idx == `TEL_REG_IRQ_CLEAR;
	assign irq_en_wr = wr_en && irq_page && reg_idx == `TEL_REG_IRQ_ENABLE;
	assign rd_data = rd_data_reg;
	assign irq = irq_reg;
	assign thread_state = thread_state_reg;

	genvar t;
	generate
		for (t = 0; t < NUM_THREADS; t = t + 1) begin : g_thr
			wire sel;
			wire wr_dly_lo;
			wire wr_dly_hi;
			wire wr_en_lo;
			wire wr_en_hi;
			wire wr_pend_lo;
			wire wr_pend_hi;
			wire wr_period;
			wire wr_set;
			wire wr_thr;
			wire thr_reset;
			wire rd_dly_lo;
			wire iv;
			wire [1:0] op;
			wire [3:0] num;
			wire [EVT_W-1:0] num_mask;
			wire [EVT_W-1:0] wait_mask;
			wire wait_hit;
			wire [EVT_W-1:0] instr_clr;
			wire [EVT_W-1:0] set_mask;
			wire [EVT_W-1:0] flags;
			wire [CNT_W-1:0] count;
			wire start_timed;
			wire done;
			reg [7:0] event_enable_low_reg;
			reg [7:0] event_enable_high_reg;
			reg [PSC_W-1:0] prescale_period_reg;
			reg [7:0] dly_wbuf_reg;
			reg [`TEL_DLY_HI_W-1:0] dly_rbuf_reg;
			reg [1:0] state_reg;
			reg [3:0] wait_num_reg;

			assign sel = (thr_idx == t);
			assign wr_dly_lo = wr_en && sel && reg_idx == `TEL_REG_DLY_LO;
			assign wr_dly_hi = wr_en && sel && reg_idx == `TEL_REG_DLY_HI;
			assign wr_en_lo = wr_en && sel && reg_idx == `TEL_REG_EN_LO;
			assign wr_en_hi = wr_en && sel && reg_idx == `TEL_REG_EN_HI;
			assign wr_pend_lo = wr_en && sel && reg_idx == `TEL_REG_PEND_LO;
			assign wr_pend_hi = wr_en && sel && reg_idx == `TEL_REG_PEND_HI;
			assign wr_period = wr_en && sel && reg_idx == `TEL_REG_PERIOD;
			assign wr_set = wr_en && sel && reg_idx == `TEL_REG_SET_CTRL;
			assign wr_thr = wr_en && sel && reg_idx == `TEL_REG_THR_CTRL;
			assign thr_reset = wr_thr && wr_data[`TEL_THR_RESET_BIT];
			assign rd_dly_lo = rd_en && sel && reg_idx == `TEL_REG_DLY_LO;

			assign iv = instr_valid[t];
			assign op = instr_op[t*2 +: 2];
			assign num = instr_evt[t*4 +: 4];
			assign num_mask = {{(EVT_W-1){1'b0}}, 1'b1} << num;
			assign wait_mask = {{(EVT_W-1){1'b0}}, 1'b1} << wait_num_reg;
			assign wait_hit = (state_reg == `TEL_ST_WAIT_EVT) && |(flags & wait_mask);
			// Await consumes the flag it finds; a waiting thread consumes it on arrival
			assign instr_clr = ((iv && (op == `TEL_OP_CLEAR || op == `TEL_OP_AWAIT))
				? num_mask : {EVT_W{1'b0}})
				| (wait_hit ? wait_mask : {EVT_W{1'b0}});
			// Group select shifts the four set bits onto one nibble of flags
			assign set_mask = wr_set
				? ({{(EVT_W-4){1'b0}}, wr_data[`TEL_SET_BITS_HI:`TEL_SET_BITS_LO]}
				<< {wr_data[`TEL_SET_SEL_HI:`TEL_SET_SEL_LO], 2'b00})
				: {EVT_W{1'b0}};
			assign start_timed = iv && op == `TEL_OP_TIMED && !thr_reset;

			tel_pending #(
				.EVT_W(EVT_W)
			) u_pending (
				.clk(clk),
				.arst_n(arst_n),
				.ce(ce),
				.evt(evt_in[t*EVT_W +: EVT_W]),
				.accept_en({event_enable_high_reg, event_enable_low_reg}),
				.instr_clr(instr_clr),
				.wr_lo(wr_pend_lo),
				.wr_hi(wr_pend_hi),
				.wr_data(wr_data),
				.set_mask(set_mask),
				.flags(flags)
			);

			tel_delay #(
				.CNT_W(CNT_W),
				.PSC_W(PSC_W)
			) u_delay (
				.clk(clk),
				.arst_n(arst_n),
				.ce(ce),
				.start(start_timed),
				.thr_reset(thr_reset),
				.load(wr_dly_hi),
				.load_value({wr_data[`TEL_DLY_HI_W-1:0], dly_wbuf_reg}),
				.prescale_period(prescale_period_reg),
				.count(count),
				.busy(),
				.done(done)
			);

			// Software-owned settings; the unit itself never writes them
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					event_enable_low_reg <= `TEL_BYTE_RST;
					event_enable_high_reg <= `TEL_BYTE_RST;
					prescale_period_reg <= {PSC_W{1'b0}};
				end else if (ce) begin
					if (wr_en_lo) begin
						event_enable_low_reg <= wr_data;
					end
					if (wr_en_hi) begin
						event_enable_high_reg <= wr_data;
					end
					if (wr_period) begin
						prescale_period_reg <= wr_data[PSC_W-1:0];
					end
				end
			end

			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					dly_wbuf_reg <= `TEL_BYTE_RST;
					dly_rbuf_reg <= {`TEL_DLY_HI_W{1'b0}};
					state_reg <= `TEL_ST_STOPPED;
					wait_num_reg <= 4'h0;
				end else if (ce) begin
					// Low byte waits here until the high byte write commits both
					if (wr_dly_lo) begin
						dly_wbuf_reg <= wr_data;
					end
					// Snapshot keeps the pair coherent while the counter runs
					if (rd_dly_lo) begin
						dly_rbuf_reg <= count[CNT_W-1:8];
					end
					if (thr_reset) begin
						state_reg <= `TEL_ST_STOPPED;
					end else if (iv) begin
						case (op)
							`TEL_OP_START: begin
								state_reg <= `TEL_ST_ACTIVE;
							end
							`TEL_OP_CLEAR: begin
								state_reg <= `TEL_ST_ACTIVE;
							end
							`TEL_OP_AWAIT: begin
								wait_num_reg <= num;
								if (|(flags & num_mask)) begin
									state_reg <= `TEL_ST_ACTIVE;
								end else begin
									state_reg <= `TEL_ST_WAIT_EVT;
								end
							end
							`TEL_OP_TIMED: begin
								state_reg <= `TEL_ST_WAIT_DLY;
							end
							default: begin
								state_reg <= state_reg;
							end
						endcase
					end else if (wait_hit || (done && state_reg == `TEL_ST_WAIT_DLY)) begin
						state_reg <= `TEL_ST_ACTIVE;
					end
				end
			end

			assign en_flat[t*EVT_W +: EVT_W] = {event_enable_high_reg, event_enable_low_reg};
			assign pend_flat[t*EVT_W +: EVT_W] = flags;
			assign period_flat[t*PSC_W +: PSC_W] = prescale_period_reg;
			assign count_flat[t*CNT_W +: CNT_W] = count;
			assign rbuf_flat[t*`TEL_DLY_HI_W +: `TEL_DLY_HI_W] = dly_rbuf_reg;
			assign state_flat[t*2 +: 2] = state_reg;
			assign done_flat[t] = done;
		end
	endgenerate

	// Read answer is registered; unmapped addresses and reserved bits give zero
	always @* begin
		rd_data_next = 8'h00;
		if (irq_page) begin
			case (reg_idx)
				`TEL_REG_IRQ_STATUS: begin
					rd_data_next[NUM_THREADS-1:0] = irq_status_reg;
				end
				`TEL_REG_IRQ_ENABLE: begin
					rd_data_next[NUM_THREADS-1:0] = irq_enable_reg;
				end
				default: begin
					rd_data_next = 8'h00;
				end
			endcase
		end else if (thr_idx < NUM_THREADS) begin
			case (reg_idx)
				`TEL_REG_DLY_LO: begin
					rd_data_next = count_flat[thr_idx*CNT_W +: 8];
				end
				`TEL_REG_DLY_HI: begin
					rd_data_next[`TEL_DLY_HI_W-1:0] =
						rbuf_flat[thr_idx*`TEL_DLY_HI_W +: `TEL_DLY_HI_W];
				end
				`TEL_REG_EN_LO: begin
					rd_data_next = en_flat[thr_idx*EVT_W +: 8];
				end
				`TEL_REG_EN_HI: begin
					rd_data_next = en_flat[thr_idx*EVT_W + 8 +: 8];
				end
				`TEL_REG_PEND_LO: begin
					rd_data_next = pend_flat[thr_idx*EVT_W +: 8];
				end
				`TEL_REG_PEND_HI: begin
					rd_data_next = pend_flat[thr_idx*EVT_W + 8 +: 8];
				end
				`TEL_REG_PERIOD: begin
					rd_data_next[PSC_W-1:0] = period_flat[thr_idx*PSC_W +: PSC_W];
				end
				`TEL_REG_SET_CTRL: begin
					rd_data_next = 8'h00;
				end
				`TEL_REG_THR_CTRL: begin
					rd_data_next[`TEL_THR_STATE_HI:`TEL_THR_STATE_LO] = state_flat[thr_idx*2 +: 2];
				end
				default: begin
					rd_data_next = 8'h00;
				end
			endcase
		end
	end

	// A delay completion in the clearing cycle survives the clear
	always @* begin
		irq_status_next = irq_status_reg;
		if (irq_clr_wr) begin
			irq_status_next = irq_status_next & ~wr_data[NUM_THREADS-1:0];
		end
		irq_status_next = irq_status_next | done_flat;
	end

	// Read answer stands for one cycle only, so a bus OR of several slaves stays clean
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_reg <= 8'h00;
		end else if (ce) begin
			if (rd_en) begin
				rd_data_reg <= rd_data_next;
			end else begin
				rd_data_reg <= 8'h00;
			end
		end
	end

	// Uses next status so the line rises in the cycle after completion
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_reg <= 1'b0;
			irq_status_reg <= {NUM_THREADS{1'b0}};
			irq_enable_reg <= {NUM_THREADS{1'b0}};
		end else if (ce) begin
			irq_status_reg <= irq_status_next;
			if (irq_en_wr) begin
				irq_enable_reg <= wr_data[NUM_THREADS-1:0];
			end
			irq_reg <= |(irq_status_next & irq_enable_reg);
		end
	end

	// Registered copy of the thread states; lags the internal state by one cycle
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			thread_state_reg <= {(NUM_THREADS*2){1'b0}};
		end else if (ce) begin
			thread_state_reg <= state_flat;
		end
	end
endmodule // tel_top

/* tb/tel_host.sv */
// Host processor model on the register port
`timescale 1ns/10ps
module tel_host (
	input wire clk,
	output logic [7:0] addr,
	output logic [7:0] wr_data,
	output logic wr_en,
	output logic rd_en,
	input wire [7:0] rd_data
);
	initial begin
		addr = 8'h00;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		// Inverted after the strobe so stale data cannot pass for fresh
		wr_data <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask
endmodule // tel_host

/* tb/tel_top_asserts.sv */
// Port checker for the thread event latch top
`timescale 1ns/10ps
module tel_top_chk #(
	parameter NUM_THREADS = 6,
	parameter EVT_W = 16,
	parameter CNT_W = 12,
	parameter PSC_W = 8
) (
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire [7:0] addr,
	input wire [7:0] wr_data,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] rd_data,
	input wire [NUM_THREADS*EVT_W-1:0] evt_in,
	input wire [NUM_THREADS-1:0] instr_valid,
	input wire [NUM_THREADS*2-1:0] instr_op,
	input wire [NUM_THREADS*4-1:0] instr_evt,
	input wire [NUM_THREADS*2-1:0] thread_state,
	input wire irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire [3:0] r = addr[3:0];
	wire [3:0] p = addr[7:4];
	wire rq = rd_en && ce;
	wire wq = wr_en && ce;
	a_rd_idle_zero: assert property (
		$past(ce) && !$past(rd_en) |-> rd_data == 8'h00)
		else $error("read data not zero outside answer");
	a_unmapped_zero: assert property (
		rq && (p > 4'h6 || (p == 4'h6 ? r > 4'h2 : r > 4'h8)) |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_setctl_reads_zero: assert property (
		rq && p < 4'h6 && r == 4'h7 |=> rd_data == 8'h00)
		else $error("set control read not zero");
	a_dly_hi_resv: assert property (
		rq && p < 4'h6 && r == 4'h1 |=> rd_data[7:4] == 4'h0)
		else $error("counter high reserved bits set");
	a_thr_reset_stop: assert property (
		wq && addr == 8'h08 && wr_data[6] && !instr_valid[0] ##1 ce
		|=> thread_state[1:0] == 2'h0)
		else $error("thread reset did not stop thread");
	a_timed_state: assert property (
		ce && instr_valid[0] && instr_op[1:0] == 2'h3 && !(wq && addr == 8'h08) ##1 ce
		|=> thread_state[1:0] == 2'h3)
		else $error("timed wait state code wrong");
	a_thread_isolated: assert property (
		ce && instr_valid == 6'h01 ##1 ce |=> $stable(thread_state[11:2]))
		else $error("other thread state moved");
	a_irq_masked_off: assert property (wq && addr == 8'h62 && wr_data == 8'h00
		##1 !(wr_en && addr == 8'h62) |=> !irq)
		else $error("irq high with all enables off");
endmodule // tel_top_chk

/* tb/test_tel_top.sv */
// Self-checking bench for the thread event latch top
`timescale 1ns/10ps
module test_tel_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [95:0] evt_in = '0;
	logic [5:0] instr_valid = '0;
	logic [11:0] instr_op = '0;
	logic [23:0] instr_evt = '0;
	wire [7:0] addr, wr_data, rd_data;
	wire wr_en, rd_en, irq;
	wire [11:0] thread_state;
	logic [7:0] v;
	int mismatches = 0;
	int check_count = 0;
	int c1, c2, c3;
	always #10 clk = ~clk;
	tel_host host (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data));
	tel_top DUT (.clk(clk), .arst_n(arst_n), .ce(1'b1), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .evt_in(evt_in),
		.instr_valid(instr_valid), .instr_op(instr_op), .instr_evt(instr_evt),
		.thread_state(thread_state), .irq(irq));
	task chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, v);
		chk(v, e);
	endtask
	task pulse(input int t, input logic [15:0] m);
		@(posedge clk);
		evt_in[t*16+:16] <= m;
		@(posedge clk);
		evt_in <= '0;
	endtask
	task op(input logic [1:0] o, input logic [3:0] e);
		@(posedge clk);
		instr_valid[0] <= 1'b1;
		instr_op[1:0] <= o;
		instr_evt[3:0] <= e;
		@(posedge clk);
		instr_valid <= '0;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task load(input logic [7:0] p, input logic [7:0] n);
		host.wr(8'h06, p);
		host.wr(8'h00, n);
		host.wr(8'h01, 8'h00);
		op(2'h3, 4'h0);
	endtask
	task run(input logic [7:0] p, input logic [7:0] n, output int c);
		load(p, n);
		c = 0;
		while (irq !== 1'b1 && c < 300) begin
			@(posedge clk);
			c++;
		end
		rc(8'h60, 8'h01);
		host.wr(8'h61, 8'h01);
		rc(8'h60, 8'h00);
		chk(irq, 1'b0);
	endtask
	task stop_test;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200us;
		mismatches++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 9; i++) rc(8'h50 + i[7:0], 8'h00);
		rc(8'h62, 8'h00);
		host.wr(8'h9a, 8'h5a);
		rc(8'h9a, 8'h00);
		$display("test reset done");
		host.wr(8'h02, 8'h05);
		pulse(0, 16'h0007);
		pulse(1, 16'h0001);
		rc(8'h04, 8'h05);
		rc(8'h14, 8'h00);
		host.wr(8'h03, 8'h80);
		pulse(0, 16'h8000);
		rc(8'h05, 8'h80);
		host.wr(8'h04, 8'h01);
		rc(8'h04, 8'h04);
		host.wr(8'h05, 8'h00);
		rc(8'h05, 8'h80);
		fork
			host.wr(8'h04, 8'h04);
			pulse(0, 16'h0004);
		join
		rc(8'h04, 8'h00);
		pulse(0, 16'h0001);
		op(2'h1, 4'h0);
		rc(8'h04, 8'h00);
		pulse(0, 16'h0001);
		fork
			op(2'h1, 4'h0);
			host.wr(8'h04, 8'h00);
		join
		rc(8'h04, 8'h01);
		op(2'h1, 4'h0);
		op(2'h0, 4'h0);
		op(2'h2, 4'h3);
		cyc(2);
		chk(thread_state[1:0], 2'h2);
		host.wr(8'h07, 8'h08);
		cyc(3);
		chk(thread_state[1:0], 2'h1);
		rc(8'h04, 8'h00);
		$display("test pending done");
		for (int s = 0; s < 4; s++) host.wr(8'h27, {2'b00, s[1:0], 4'h9});
		rc(8'h24, 8'h99);
		rc(8'h25, 8'h99);
		rc(8'h27, 8'h00);
		$display("test set port done");
		host.wr(8'h00, 8'h34);
		host.wr(8'h01, 8'h0a);
		rc(8'h00, 8'h34);
		rc(8'h01, 8'h0a);
		host.wr(8'h00, 8'h55);
		rc(8'h00, 8'h34);
		host.wr(8'h01, 8'h0a);
		rc(8'h00, 8'h55);
		rc(8'h01, 8'h0a);
		host.wr(8'h62, 8'h01);
		run(8'h03, 8'h02, c1);
		run(8'h03, 8'h03, c2);
		run(8'h02, 8'h02, c3);
		chk(16'(c2 - c1), 16'h0004);
		chk(16'(c1 - c3), 16'h0002);
		rc(8'h00, 8'h00);
		$display("test delay done");
		host.wr(8'h62, 8'h00);
		load(8'h00, 8'h01);
		cyc(10);
		chk(irq, 1'b0);
		rc(8'h60, 8'h01);
		host.wr(8'h62, 8'h01);
		cyc(2);
		chk(irq, 1'b1);
		rc(8'h62, 8'h01);
		host.wr(8'h61, 8'h01);
		cyc(2);
		chk(irq, 1'b0);
		$display("test irq done");
		load(8'hff, 8'hff);
		cyc(3);
		chk(thread_state[1:0], 2'h3);
		host.wr(8'h08, 8'h40);
		cyc(3);
		chk(thread_state[1:0], 2'h0);
		rc(8'h08, 8'h00);
		$display("test thread reset done");
		stop_test;
	end
endmodule // test_tel_top
bind tel_top tel_top_chk #(.NUM_THREADS(NUM_THREADS), .EVT_W(EVT_W), .CNT_W(CNT_W),
	.PSC_W(PSC_W)) u_chk (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
	.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .evt_in(evt_in),
	.instr_valid(instr_valid), .instr_op(instr_op), .instr_evt(instr_evt),
	.thread_state(thread_state), .irq(irq));
